/* File: core/vcf_formatter.sv */
//
// Summary of operation
// - Larger input: send only the stored cutout window
// - Smaller input: centre it, black all around
// - No scaling; one input pixel per output
// - HDMI Raw shown monochrome, no demosaic
// - HDMI Raw keeps top eight bits as grey
// - HDMI mode may feed USB at once
// - USB copy formats as UVC, shared clipping
// - No USB copy when rate exceeds USB
// - Switch 8 on, 7 off: UVC mode
// - UVC offers UYVY, YUY2, RGB24 by setting
// - UVC Raw10/12 zero-extended to 16, UYVY slot
// - UVC Raw20 zero-extended to 24, RGB24 slot
// - Raw20 padding raises rate six fifths
// - Factory UVC setting 1920x1080, 30 fps, UYVY
// - Switch 8 off, 7 off: HDMI mode
// - HDMI pixels are YUV 4:2:2 or RGB24
`timescale 1ns/10ps
module vcf_formatter
  import vcf_pkg::*;
#(
  parameter int LINE_DEPTH = 8192
) (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [vcf_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Pixel link from the receiver, foreign clock
  input  wire logic                   lnk_clk,
  input  wire logic                   lnk_fv,
  input  wire logic                   lnk_lv,
  input  wire logic [vcf_pkg::PIX_W-1:0] lnk_data,
  // Board switches
  input  wire logic                   mode_sw8,
  input  wire logic                   mode_sw7,
  input  wire logic [1:0]             lane_sw,
  // HDMI pixel stream
  output logic                        hdmi_valid,
  output logic                        hdmi_sof,
  output logic                        hdmi_eol,
  output logic [vcf_pkg::PIX_W-1:0]   hdmi_data,
  output logic                        hdmi_rgb,
  // UVC pixel stream
  output logic                        uvc_valid,
  output logic                        uvc_sof,
  output logic                        uvc_eol,
  output logic [vcf_pkg::PIX_W-1:0]   uvc_data,
  output logic [1:0]                  uvc_fmt,
  // Mode taken from the switches
  output logic                        mode_uvc
);
  import vcf_pkg::*;

  localparam int AW = $clog2(LINE_DEPTH);
  localparam int SW = PIX_W + 7;           // Width of the synchronised bundle

  // Refuse a line store that cannot hold a line
  if (LINE_DEPTH < 16 || LINE_DEPTH > 8192)
  begin : g_chk
    $error("vcf_formatter: LINE_DEPTH out of range");
  end

  // Grey level: the top eight bits of a Raw sample
  function automatic logic [7:0] grey_f(input logic [2:0] f, input logic [PIX_W-1:0] d);
    logic [7:0] g;
    g = d[7:0];
    unique case (f)
      IN_RAW10: g = d[9:2];
      IN_RAW12: g = d[11:4];
      IN_RAW20: g = d[19:12];
      default:  g = d[7:0];
    endcase
    return g;
  endfunction : grey_f

  // Raw format test
  function automatic logic is_raw_f(input logic [2:0] f);
    return (f == IN_RAW8) || (f == IN_RAW10) || (f == IN_RAW12) || (f == IN_RAW20);
  endfunction : is_raw_f

  // Software registers
  logic [1:0]       ctrl;                  // Crop enable, USB copy enable
  logic [2:0]       in_fmt;                // Input sample format
  logic [DIM_W-1:0] in_w, in_h;            // Input frame size
  logic [DIM_W-1:0] out_w, out_h;          // Output raster size
  logic [DIM_W-1:0] crop_x, crop_y;        // Cutout origin
  logic [1:0]       uvc_sel;               // Requested UVC format
  logic [7:0]       fps;                   // UVC frame rate

  // Synchroniser and link edge tracking
  logic [SW-1:0]    sync1, sync2;          // Two-stage capture of the pins
  logic             clk_q, lv_q, fv_q;     // Previous synchronised levels
  logic [1:0]       strap_cnt;             // Strap capture delay
  logic             strap_done;            // Mode has been latched
  logic [2:0]       lanes;                 // Lane count shown in status

  // Input side counters and flags
  logic [DIM_W-1:0] in_col, in_row;        // Position of next input pixel
  logic             line_ready;            // A full line waits in the store
  logic             frame_done;            // Input frame has ended

  // Output sequencer
  vcf_state_t       state, next_state;
  logic [DIM_W-1:0] out_x, out_row;        // Output raster position
  logic             line_black;            // Current line is border only
  logic             p_valid, p_sof, p_eol, p_in; // Pipeline beside the store read
  logic             usb_ok;                // USB link can carry the stream

  vcf_mem_if #(.AW(AW), .DW(PIX_W)) mbus ();

  vcf_line_mem #(.DEPTH(LINE_DEPTH), .AW(AW), .DW(PIX_W)) u_mem (
    .core_clk (core_clk),
    .bus      (mbus)
  );

  // Synchronised link and switch levels
  wire s_clk = sync2[SW-1];
  wire s_fv  = sync2[SW-2];
  wire s_lv  = sync2[SW-3];
  wire [PIX_W-1:0] s_data = sync2[PIX_W+3:4];
  wire pix_take  = s_clk & ~clk_q & s_fv & s_lv;
  wire line_end  = lv_q & ~s_lv & s_fv;
  wire frame_end = fv_q & ~s_fv;
  wire frame_beg = ~fv_q & s_fv;

  // Window arithmetic: crop when larger, pad when smaller
  wire w_big = in_w >= out_w;
  wire h_big = in_h >= out_h;
  wire [DIM_W-1:0] off_x = (w_big && ctrl[CTRL_CROP_EN]) ? crop_x : '0;
  wire [DIM_W-1:0] off_y = (h_big && ctrl[CTRL_CROP_EN]) ? crop_y : '0;
  wire [DIM_W-1:0] pad_x = w_big ? '0 : DIM_W'((out_w - in_w) >> 1);
  wire [DIM_W-1:0] pad_y = h_big ? '0 : DIM_W'((out_h - in_h) >> 1);
  wire [DIM_W-1:0] wr_col = in_col - off_x;
  wire [DIM_W-1:0] wr_row = in_row - off_y;
  wire col_in_win = (in_col >= off_x) && (wr_col < out_w);
  wire row_in_win = (in_row >= off_y) && (wr_row < out_h);
  wire [DIM_W-1:0] rd_col = out_x - pad_x;
  wire x_inside = (out_x >= pad_x) && (rd_col < in_w);

  // Store traffic: one slot per input pixel, no scaling
  assign mbus.wr_en   = pix_take & col_in_win;
  assign mbus.wr_addr = wr_col[AW-1:0];
  assign mbus.wr_data = s_data;
  assign mbus.rd_addr = rd_col[AW-1:0];

  // APB decode
  wire        setup   = psel & ~penable;
  wire        wr_acc  = psel & penable & pwrite & pready;
  wire        mapped  = (paddr <= REG_STATUS) && (paddr[1:0] == 2'h0);
  // Code 3 names no format, so a write of it keeps the format already chosen
  wire [1:0]  uvc_sel_wr = (pwdata[1:0] == 2'h3) ? uvc_sel : pwdata[1:0];
  wire [31:0] st_word = {16'h0, 3'h0, out_row[DIM_W-1:DIM_W-5] != 5'h0, frame_done,
                         line_ready, lanes, usb_ok, strap_done, mode_uvc, 3'h0, s_fv};
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    unique case (paddr)
      REG_CTRL:     rd_mux = {30'h0, ctrl};
      REG_IN_FMT:   rd_mux = {29'h0, in_fmt};
      REG_IN_SIZE:  rd_mux = {3'h0, in_h, 3'h0, in_w};
      REG_OUT_SIZE: rd_mux = {3'h0, out_h, 3'h0, out_w};
      REG_CROP_POS: rd_mux = {3'h0, crop_y, 3'h0, crop_x};
      REG_HDMI_FMT: rd_mux = {31'h0, hdmi_rgb};
      REG_UVC_CFG:  rd_mux = {16'h0, fps, 6'h0, uvc_sel};
      REG_STATUS:   rd_mux = st_word;
      default:      rd_mux = 32'h0;
    endcase
  end

  // APB answer: zero wait states, read data latched in the setup cycle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (setup)
      begin
        prdata  <= rd_mux;
        pslverr <= ~mapped;
      end
    end
  end

  // Register writes; resets give the factory UVC setting
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl     <= RST_CTRL;
      in_fmt   <= RST_IN_FMT;
      in_w     <= RST_W;
      in_h     <= RST_H;
      out_w    <= RST_W;
      out_h    <= RST_H;
      crop_x   <= '0;
      crop_y   <= '0;
      hdmi_rgb <= 1'b0;
      uvc_sel  <= RST_UVC_FMT;
      fps      <= RST_FPS;
    end
    else if (wr_acc)
    begin
      unique case (paddr)
        REG_CTRL:     ctrl <= pwdata[1:0];
        REG_IN_FMT:   in_fmt <= pwdata[2:0];
        REG_IN_SIZE:  {in_h, in_w} <= {pwdata[SIZE_H_LSB+:DIM_W], pwdata[DIM_W-1:0]};
        REG_OUT_SIZE: {out_h, out_w} <= {pwdata[SIZE_H_LSB+:DIM_W], pwdata[DIM_W-1:0]};
        REG_CROP_POS: {crop_y, crop_x} <= {pwdata[SIZE_H_LSB+:DIM_W], pwdata[DIM_W-1:0]};
        REG_HDMI_FMT: hdmi_rgb <= pwdata[0];
        REG_UVC_CFG:  {fps, uvc_sel} <= {pwdata[UVC_FPS_LSB+:8], uvc_sel_wr};
        default:      ;
      endcase
    end
  end

  // Two flip-flops on every foreign input; only sync2 is read further on
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sync1 <= '0;
      sync2 <= '0;
      clk_q <= 1'b0;
      lv_q  <= 1'b0;
      fv_q  <= 1'b0;
    end
    else
    begin
      sync1 <= {lnk_clk, lnk_fv, lnk_lv, lnk_data, mode_sw8, mode_sw7, lane_sw};
      sync2 <= sync1;
      clk_q <= s_clk;
      lv_q  <= s_lv;
      fv_q  <= s_fv;
    end
  end

  // Switch straps are caught once the synchroniser has filled after reset
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      strap_cnt  <= 2'h0;
      strap_done <= 1'b0;
      mode_uvc   <= 1'b0;
      lanes      <= 3'h4;
    end
    else if (!strap_done)
    begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == STRAP_WAIT)
      begin
        strap_done <= 1'b1;
        // Switch 7 on is undocumented and falls back to HDMI
        mode_uvc   <= sync2[3] & ~sync2[2];
        lanes      <= {1'b0, sync2[1:0]} + 3'h1;
      end
    end
  end

  // Input position counters
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      in_col <= '0;
      in_row <= '0;
    end
    else
    begin
      if (frame_beg)
        in_row <= '0;
      else if (line_end)
        in_row <= in_row + DIM_W'(1);
      if (line_end || frame_beg)
        in_col <= '0;
      else if (pix_take)
        in_col <= in_col + DIM_W'(1);
    end
  end

  // Line and frame flags; a set in the clearing cycle wins
  wire start_data = (state == ST_IDLE) && (out_row >= pad_y) && line_ready && (out_row < out_h);
  wire wrap       = (state == ST_IDLE) && !start_data && (out_row >= pad_y) && frame_done
                    && (out_row >= out_h);
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      line_ready <= 1'b0;
      frame_done <= 1'b0;
    end
    else
    begin
      line_ready <= (line_end && row_in_win) || (line_ready && !start_data);
      frame_done <= frame_end || (frame_done && !wrap);
    end
  end

  // Sequencer: top border, data lines, bottom border, then next top border
  wire top_pad = (out_row < pad_y);
  wire bot_pad = frame_done && !line_ready && (out_row < out_h) && !top_pad;
  wire line_last = (out_x == out_w - DIM_W'(1));
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (top_pad || start_data || bot_pad) next_state = ST_LINE;
      ST_LINE: if (line_last) next_state = ST_IDLE;
    endcase
  end

  // Output raster position and line kind
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state      <= ST_IDLE;
      out_x      <= '0;
      out_row    <= '0;
      line_black <= 1'b1;
    end
    else
    begin
      state <= next_state;
      if (state == ST_IDLE)
      begin
        out_x      <= '0;
        line_black <= !start_data;
        if (wrap)
          out_row <= '0;
      end
      else if (line_last)
        out_row <= out_row + DIM_W'(1);
      else
        out_x <= out_x + DIM_W'(1);
    end
  end

  // Flags travel beside the one-cycle store read
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      p_valid <= 1'b0;
      p_sof   <= 1'b0;
      p_eol   <= 1'b0;
      p_in    <= 1'b0;
    end
    else
    begin
      p_valid <= (state == ST_LINE);
      p_sof   <= (state == ST_LINE) && (out_x == '0) && (out_row == '0);
      p_eol   <= (state == ST_LINE) && line_last;
      p_in    <= (state == ST_LINE) && !line_black && x_inside;
    end
  end

  // HDMI pixel: Raw becomes grey, border takes the format's black
  wire [7:0] grey = grey_f(in_fmt, mbus.rd_data);
  logic [PIX_W-1:0] hdmi_pix;
  always_comb
  begin
    if (!p_in)
      hdmi_pix = hdmi_rgb ? 24'h000000 : {8'h00, BLACK_C, BLACK_Y};
    else if (is_raw_f(in_fmt))
      hdmi_pix = hdmi_rgb ? {grey, grey, grey} : {8'h00, BLACK_C, grey};
    else
      hdmi_pix = hdmi_rgb ? mbus.rd_data : {8'h00, mbus.rd_data[15:0]};
  end

  // UVC pixel: Raw zero-extended into the slot its width needs
  logic [PIX_W-1:0] uvc_pix;
  logic [1:0]       uvc_slot;
  always_comb
  begin
    uvc_slot = uvc_sel;
    uvc_pix  = mbus.rd_data;
    if (in_fmt == IN_RAW20)
    begin
      uvc_slot = UVC_RGB24;
      uvc_pix  = {4'h0, mbus.rd_data[19:0]};
    end
    else if (is_raw_f(in_fmt))
    begin
      uvc_slot = UVC_UYVY;
      uvc_pix  = (in_fmt == IN_RAW10) ? {14'h0, mbus.rd_data[9:0]} :
                 (in_fmt == IN_RAW12) ? {12'h0, mbus.rd_data[11:0]} :
                                        {16'h0, mbus.rd_data[7:0]};
    end
    else if (uvc_sel == UVC_YUY2)
      uvc_pix = {8'h00, mbus.rd_data[7:0], mbus.rd_data[15:8]};
    if (!p_in)
      uvc_pix = (uvc_slot == UVC_RGB24) ? 24'h000000 :
                (uvc_slot == UVC_YUY2) ? {8'h00, BLACK_Y, BLACK_C} : {8'h00, BLACK_C, BLACK_Y};
  end

  // USB load check; Raw20 counts at 24 bits, six fifths of its own width
  wire [4:0]  uvc_bpp  = (in_fmt == IN_RAW20 || (!is_raw_f(in_fmt) && uvc_sel == UVC_RGB24))
                         ? 5'h18 : 5'h10;
  wire [39:0] usb_rate = 40'(out_w) * 40'(out_h) * 40'(uvc_bpp) * 40'(fps);
  wire uvc_on = mode_uvc || (ctrl[CTRL_SIM_EN] && usb_ok);

  // Stream outputs, all from flip-flops; HDMI idles in UVC mode
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      usb_ok     <= 1'b0;
      hdmi_valid <= 1'b0;
      hdmi_sof   <= 1'b0;
      hdmi_eol   <= 1'b0;
      hdmi_data  <= '0;
      uvc_valid  <= 1'b0;
      uvc_sof    <= 1'b0;
      uvc_eol    <= 1'b0;
      uvc_data   <= '0;
      uvc_fmt    <= RST_UVC_FMT;
    end
    else
    begin
      usb_ok     <= (usb_rate <= USB_MAX_BPS);
      hdmi_valid <= p_valid && strap_done && !mode_uvc;
      hdmi_sof   <= p_sof && strap_done && !mode_uvc;
      hdmi_eol   <= p_eol && strap_done && !mode_uvc;
      hdmi_data  <= hdmi_pix;
      // Same pixels and window as HDMI, formatted as in UVC-only mode
      uvc_valid  <= p_valid && strap_done && uvc_on;
      uvc_sof    <= p_sof && strap_done && uvc_on;
      uvc_eol    <= p_eol && strap_done && uvc_on;
      uvc_data   <= uvc_pix;
      uvc_fmt    <= uvc_slot;
    end
  end
endmodule : vcf_formatter

/* File: core/vcf_pkg.sv */
package vcf_pkg;

  // Geometry and data widths
  localparam int DIM_W  = 13;              // Up to 8191 pixels per side
  localparam int PIX_W  = 24;              // Widest sample on the link
  localparam int APB_AW = 12;              // Decoded APB address bits

  // Register byte offsets
  localparam logic [APB_AW-1:0] REG_CTRL     = 12'h000;
  localparam logic [APB_AW-1:0] REG_IN_FMT   = 12'h004;
  localparam logic [APB_AW-1:0] REG_IN_SIZE  = 12'h008;
  localparam logic [APB_AW-1:0] REG_OUT_SIZE = 12'h00C;
  localparam logic [APB_AW-1:0] REG_CROP_POS = 12'h010;
  localparam logic [APB_AW-1:0] REG_HDMI_FMT = 12'h014;
  localparam logic [APB_AW-1:0] REG_UVC_CFG  = 12'h018;
  localparam logic [APB_AW-1:0] REG_STATUS   = 12'h01C;

  // Field positions
  localparam int CTRL_CROP_EN = 0;         // Cutout window enable
  localparam int CTRL_SIM_EN  = 1;         // USB copy while in HDMI mode
  localparam int SIZE_H_LSB   = 16;        // Height / y field start
  localparam int UVC_FPS_LSB  = 8;         // Frame rate field start

  // Input sample formats
  localparam logic [2:0] IN_YUV8  = 3'h0;
  localparam logic [2:0] IN_RGB24 = 3'h1;
  localparam logic [2:0] IN_RAW8  = 3'h2;
  localparam logic [2:0] IN_RAW10 = 3'h3;
  localparam logic [2:0] IN_RAW12 = 3'h4;
  localparam logic [2:0] IN_RAW20 = 3'h5;

  // UVC pixel formats
  localparam logic [1:0] UVC_UYVY  = 2'h0;
  localparam logic [1:0] UVC_YUY2  = 2'h1;
  localparam logic [1:0] UVC_RGB24 = 2'h2;

  // Values after reset
  localparam logic [1:0]       RST_CTRL    = 2'h2;
  localparam logic [DIM_W-1:0] RST_W       = 13'h0780;   // 1920
  localparam logic [DIM_W-1:0] RST_H       = 13'h0438;   // 1080
  localparam logic [7:0]       RST_FPS     = 8'h1E;      // 30
  localparam logic [1:0]       RST_UVC_FMT = 2'h0;       // UYVY
  localparam logic [2:0]       RST_IN_FMT  = 3'h0;

  // Black codes
  localparam logic [7:0] BLACK_Y = 8'h10;
  localparam logic [7:0] BLACK_C = 8'h80;

  // USB payload ceiling in bits per second
  localparam logic [39:0] USB_MAX_BPS = 40'h00B2D05E00;  // 3.0 Gbps

  // Strap capture waits for the synchroniser to fill
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // Output line sequencer
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b01,
    ST_LINE = 2'b10
  } vcf_state_t;

endpackage : vcf_pkg

/* File: core/vcf_mem_if.sv */
`timescale 1ns/10ps
interface vcf_mem_if #(
  parameter int AW = 13,
  parameter int DW = 24
);
  logic          wr_en;    // Write strobe
  logic [AW-1:0] wr_addr;  // Write word address
  logic [DW-1:0] wr_data;  // Write word
  logic [AW-1:0] rd_addr;  // Read word address
  logic [DW-1:0] rd_data;  // Registered read word

  // Line store user
  modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  // Line store itself
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : vcf_mem_if

/* File: core/vcf_line_mem.sv */
`timescale 1ns/10ps
module vcf_line_mem #(
  parameter int DEPTH = 8192,
  parameter int AW    = 13,
  parameter int DW    = 24
) (
  // Clock
  input wire logic core_clk,
  // Port bundle
  vcf_mem_if.mem   bus
);
  // Storage array, no reset so it maps onto block memory
  logic [DW-1:0] store [DEPTH];

  // Write port
  always_ff @(posedge core_clk)
  begin
    if (bus.wr_en)
      store[bus.wr_addr] <= bus.wr_data;
  end

  // Read port, data comes out of a register one cycle later
  always_ff @(posedge core_clk)
  begin
    bus.rd_data <= store[bus.rd_addr];
  end

  // Refuse an address too narrow for the depth
  if ((1 << AW) < DEPTH)
  begin : g_chk
    $error("vcf_line_mem: AW too small for DEPTH");
  end
endmodule : vcf_line_mem

/* File: bench/vcf_formatter_properties.sv */
`timescale 1ns/10ps
module vcf_formatter_properties
  import vcf_pkg::*;
(
  // Clock and reset
  input logic                      core_clk,
  input logic                      rst,
  // Watched outputs
  input logic                      pready,
  input logic                      mode_uvc,
  input logic                      hdmi_valid,
  input logic                      hdmi_sof,
  input logic                      hdmi_eol,
  input logic [vcf_pkg::PIX_W-1:0] hdmi_data,
  input logic                      hdmi_rgb,
  input logic                      uvc_valid,
  input logic                      uvc_sof,
  input logic                      uvc_eol,
  input logic [1:0]                uvc_fmt
);
  // One domain, so clock and reset are given once
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // Bus is never stalled once out of reset
  a_ready_after_reset: assert property ($past(rst) == 1'b0 |-> pready)
    else $error("pready low after reset");
  a_hdmi_quiet_uvc: assert property (mode_uvc |-> !hdmi_valid)
    else $error("hdmi active in uvc mode");
  // Mode is taken once; it never drops back while running
  a_mode_held: assert property (mode_uvc |=> mode_uvc)
    else $error("mode changed while running");
  a_yuv_top_zero: assert property (hdmi_valid && !hdmi_rgb |-> hdmi_data[23:16] == 8'h00)
    else $error("yuv pixel has upper byte set");
  a_uvc_fmt_legal: assert property (uvc_fmt != 2'h3)
    else $error("uvc format slot out of range");
  a_hdmi_sof_pixel: assert property (hdmi_sof |-> hdmi_valid)
    else $error("hdmi frame start without pixel");
  a_uvc_sof_pixel: assert property (uvc_sof |-> uvc_valid)
    else $error("uvc frame start without pixel");
  a_uvc_eol_pixel: assert property (uvc_eol |-> uvc_valid)
    else $error("uvc line end without pixel");
  a_sof_one_cycle: assert property (hdmi_sof |=> !hdmi_sof)
    else $error("frame start longer than one cycle");
  // Idle cycle between lines keeps line boundaries visible
  a_eol_line_gap: assert property (hdmi_eol |=> !hdmi_valid)
    else $error("no gap after line end");
endmodule : vcf_formatter_properties

bind vcf_formatter vcf_formatter_properties u_props (.*);

/* File: bench/vcf_sensor_model.sv */
`timescale 1ns/10ps
module vcf_sensor_model (
  // Link pins toward the formatter
  output logic        lnk_clk,
  output logic        lnk_fv,
  output logic        lnk_lv,
  output logic [23:0] lnk_data
);
  // Link clock stands still until a frame is sent
  initial
  begin
    lnk_clk = 1'b0;
    lnk_fv = 1'b0;
    lnk_lv = 1'b0;
    lnk_data = 24'h0;
  end

  // One link period; data moves only while the clock is low
  task automatic tick();
    #200 lnk_clk = 1'b1;
    #200 lnk_clk = 1'b0;
  endtask : tick

  // Two lines of four Raw10 samples, one sample per clock
  task automatic send_frame(input logic [9:0] p [8]);
    // Step off the core clock grid so no link edge races a core edge
    #13;
    lnk_fv = 1'b1;
    tick();
    for (int r = 0; r < 2; r++)
    begin
      lnk_lv = 1'b1;
      for (int c = 0; c < 4; c++)
      begin
        lnk_data = {14'h0, p[r*4+c]};
        tick();
      end
      // Released data is inverted so a stale sample never looks valid
      lnk_lv = 1'b0;
      lnk_data = ~lnk_data;
      tick();
      tick();
    end
    lnk_fv = 1'b0;
    tick();
  endtask : send_frame
endmodule : vcf_sensor_model

/* File: bench/tb_vcf_formatter.sv */
`timescale 1ns/10ps
module tb_vcf_formatter;
  import vcf_pkg::*;
  // Bus and control
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, mode_sw8;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  // Link and streams
  logic        lnk_clk, lnk_fv, lnk_lv, hdmi_valid, hdmi_sof, hdmi_eol, hdmi_rgb;
  logic        uvc_valid, uvc_sof, uvc_eol, mode_uvc, live, arm;
  logic [23:0] lnk_data, hdmi_data, uvc_data;
  logic [1:0]  uvc_fmt;
  // Samples and expected pixels
  logic [9:0]  px [8];
  logic [23:0] q [$];
  int          err_count, num_checks, seed;

  // Small line store keeps short frames cheap; four lanes as strapped
  vcf_formatter #(.LINE_DEPTH(64)) u_dut (.*, .mode_sw7(1'b0), .lane_sw(2'h3));
  vcf_sensor_model u_sensor (.*);

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // One APB transfer; waits for pready, read data kept in rd
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Reset for six cycles, then let the straps settle
  task automatic boot(input logic sw8);
    mode_sw8 <= sw8;
    rst <= 1'b1;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask : boot

  // Raw10 4x2 input into an ow x oh raster, cut at (cx, cy) when either is set; two frames expected
  task automatic run(input int ow, input int oh, input int cx, input int cy);
    int py, pxo, ir, ic;
    py = (oh > 2) ? (oh - 2) >> 1 : 0;
    pxo = (ow > 4) ? (ow - 4) >> 1 : 0;
    apb(1'b1, REG_CTRL, {30'h0, 1'b1, (cx + cy) != 0});
    apb(1'b1, REG_CROP_POS, {16'(cy), 16'(cx)});
    apb(1'b1, REG_IN_FMT, {29'h0, IN_RAW10});
    // Output size first: a small input under the old large raster would start a border line early
    apb(1'b1, REG_OUT_SIZE, {16'(oh), 16'(ow)});
    apb(1'b1, REG_IN_SIZE, 32'h0002_0004);
    for (int f = 0; f < 2; f++)
      for (int r = 0; r < oh; r++)
        for (int c = 0; c < ow; c++)
        begin
          ir = r - py + cy;
          ic = c - pxo + cx;
          if (ir >= 0 && ir < 2 && ic >= 0 && ic < 4)
            q.push_back(mode_uvc ? {14'h0, px[ir*4+ic]} : {8'h00, BLACK_C, px[ir*4+ic][9:2]});
          else
            q.push_back({8'h00, BLACK_C, BLACK_Y});
        end
    live = 1'b0;
    arm = 1'b1;
    repeat (4) u_sensor.send_frame(px);
    repeat (20) @(posedge core_clk);
    check(24'(q.size()), 24'h0);
    arm = 1'b0;
  endtask : run

  // Monitor: from the first frame start, every pixel takes the oldest note
  always @(negedge core_clk)
    if (arm && q.size() > 0 && (mode_uvc ? uvc_valid : hdmi_valid))
    begin
      if (mode_uvc ? uvc_sof : hdmi_sof)
        live = 1'b1;
      if (live)
        check(mode_uvc ? uvc_data : hdmi_data, q.pop_front());
    end

  initial forever #25 core_clk = ~core_clk;

  // A hang ends the run the same way as the tests
  initial
  begin
    #1000000;
    err_count++;
    print_verdict();
  end

  initial
  begin
    core_clk = 1'b0;
    {rst, psel, penable, pwrite, mode_sw8, arm, live} = 7'h41;
    paddr = 12'h0;
    pwdata = 32'h0;
    seed = 32'hd78f;
    for (int i = 0; i < 8; i++)
      px[i] = 10'($random(seed));
    boot(1'b0);
    check({23'h0, mode_uvc}, 24'h0);
    apb(1'b0, REG_UVC_CFG, 32'h0);
    check(rd[23:0], {8'h0, RST_FPS, 6'h0, RST_UVC_FMT});
    // Unmapped place is refused
    apb(1'b0, 12'h020, 32'h0);
    check({23'h0, pslverr}, 24'h1);
    run(8, 5, 0, 0);
    boot(1'b1);
    check({23'h0, mode_uvc}, 24'h1);
    run(4, 2, 0, 0);
    check({22'h0, uvc_fmt}, {22'h0, UVC_UYVY});
    // Cutout of two pixels from the second input line
    run(2, 1, 1, 1);
    print_verdict();
  end
endmodule : tb_vcf_formatter
